// ### hw/qbip_defs.vh
// Constants for the serial-flash boot image parser
`ifndef QBIP_DEFS_VH
`define QBIP_DEFS_VH

// ****************************************
// Image field byte offsets
// ****************************************
`define QBIP_OFS_KEY 12'h000
`define QBIP_OFS_SIG 12'h126
`define QBIP_OFS_ENCLEN 12'h226
`define QBIP_OFS_NONCE 12'h22A
`define QBIP_OFS_HDR1 12'h23A
`define QBIP_OFS_COMMON 12'h242
`define QBIP_OFS_VALID 12'h246
`define QBIP_OFS_ENTRY 12'h24A
`define QBIP_OFS_PLL 12'h24E
`define QBIP_OFS_FC0 12'h256
`define QBIP_OFS_FC1 12'h25A
`define QBIP_OFS_FC2 12'h25E
`define QBIP_OFS_FC3 12'h262
`define QBIP_OFS_CRC1 12'h286
`define QBIP_OFS_HDR2 12'h28A
`define QBIP_OFS_LEN 12'h28E
`define QBIP_OFS_DEST 12'h296
`define QBIP_OFS_BOOT0 12'h29E
`define QBIP_OFS_BOOT1 12'h2A2
`define QBIP_OFS_CRC2 12'h2B6
`define QBIP_OFS_PAYLOAD 12'h2BA
`define QBIP_MIC_BYTES 32'h0000_0010

// ****************************************
// Field positions and defaults
// ****************************************
`define QBIP_DIV_HI 22
`define QBIP_DIV_LO 18
`define QBIP_DIVDEF_BIT 17
`define QBIP_CLK_HI 9
`define QBIP_CLK_LO 8
`define QBIP_DMA_BIT 0
`define QBIP_REF_HI 24
`define QBIP_REF_LO 16
`define QBIP_FB_HI 15
`define QBIP_FB_LO 7
`define QBIP_PLLDEF_BIT 0
`define QBIP_OFSEN_BIT 23
`define QBIP_DIV_PLL 5'h04
`define QBIP_DIV_OTHER 5'h01
`define QBIP_CLK_DEF 2'h3
`define QBIP_REF_OSC 9'h050
`define QBIP_REF_XTAL 9'h060
`define QBIP_FB_DEF 9'h0F0
`define QBIP_CRC_INIT 16'hFFFF
`define QBIP_CRC_POLY 16'h1021

// ****************************************
// Memory ranges
// ****************************************
`define QBIP_DBUS_LO 32'h0010_0000
`define QBIP_DBUS_HI 32'h0015_7FFF
`define QBIP_SBUS_LO 32'h2000_0000
`define QBIP_SBUS_HI 32'h2001_FFFF
`define QBIP_RSV_HI 32'h2000_5657
`define QBIP_HEAP_LO 32'h2000_2658

// ****************************************
// Wishbone register map
// ****************************************
`define QBIP_REG_CTRL 8'h00
`define QBIP_REG_STATUS 8'h04
`define QBIP_REG_ENTRY 8'h08
`define QBIP_REG_LEN 8'h0C
`define QBIP_REG_DEST 8'h10
`define QBIP_REG_CLOCK 8'h14
`define QBIP_REG_PLL 8'h18
`define QBIP_REG_FOFS 8'h1C
`define QBIP_REG_ENCLEN 8'h20
`define QBIP_REG_FC0 8'h24
`define QBIP_REG_FC1 8'h28
`define QBIP_REG_FC2 8'h2C
`define QBIP_REG_BOOT0 8'h30
`define QBIP_REG_BOOT1 8'h34
`define QBIP_REG_NONCE 8'h38

`endif

// ### hw/qbip_parser.v
// Boot image parser: byte stream from serial flash, decoded settings out
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "qbip_defs.vh"

module qbip_parser #(
	parameter [31:0] VALID_WORD = 32'h1234_5678 // Arbitrary identity value
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Flash byte stream
	output reg fl_req_o,
	output reg [31:0] fl_addr_o,
	input wire fl_valid_i,
	input wire [7:0] fl_data_i,
	input wire fl_err_i,
	// Boot context straps
	input wire usb_boot_i,
	input wire signed_opt_i,
	input wire encrypted_opt_i,
	input wire deep_sleep_wake_i,
	// Decoded results
	output reg done_o,
	output reg start_o,
	output reg [31:0] entry_function_address_o,
	output reg [4:0] flash_clock_divider_o,
	output reg [1:0] system_clock_select_o,
	output reg copy_dma_enable_o,
	output reg [8:0] pll_reference_divider_o,
	output reg [8:0] pll_feedback_divider_o,
	output reg pll_default_select_o,
	output reg [31:0] flash_base_offset_o,
	output reg [31:0] mic_address_o,
	output reg [31:0] sram_init_end_o
);

	// ****************************************
	// Input synchronisers for strap pins
	// ****************************************
	reg [3:0] strap_s1_reg; // First stage, read only by second
	reg [3:0] strap_s2_reg; // Stable strap levels
	wire usb_s = strap_s2_reg[0];
	wire sgn_s = strap_s2_reg[1];
	wire enc_s = strap_s2_reg[2];
	wire wake_s = strap_s2_reg[3];

	// Strap sampling
	// Straps are pins; the first stage may go metastable, so
	// nothing but the second stage ever reads it
	always @(posedge clk_i) begin
		if (rst_i) begin
			strap_s1_reg <= 4'h0;
			strap_s2_reg <= 4'h0;
		end else begin
			strap_s1_reg <= {deep_sleep_wake_i, encrypted_opt_i, signed_opt_i, usb_boot_i};
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// ****************************************
	// Parser state
	// ****************************************
	localparam [1:0] ST_IDLE = 2'b00; // Waiting for a software kick
	localparam [1:0] ST_READ = 2'b01; // Streaming header bytes
	localparam [1:0] ST_EVAL = 2'b10; // One cycle to judge the image
	localparam [1:0] ST_DONE = 2'b11; // Verdict held; a kick here returns to idle

	reg [1:0] state_reg;
	reg [11:0] pos_reg; // Byte offset of next byte
	reg [31:0] shift_reg; // Last four bytes, little-endian assembly
	reg [15:0] crc1_reg; // Running header CRC
	reg [15:0] crc2_reg; // Running section CRC
	reg [31:0] common_setup_word_reg;
	reg [31:0] image_validity_word_reg;
	reg [31:0] entry_reg;
	reg [31:0] pll_setup_word_reg;
	reg [31:0] flash_ctrl_word0_reg;
	reg [31:0] flash_ctrl_word1_reg;
	reg [31:0] flash_ctrl_word2_reg;
	reg [31:0] flash_address_offset_word_reg;
	reg [31:0] check1_reg;
	reg [31:0] check2_reg;
	reg [31:0] payload_length_reg;
	reg [31:0] sram_destination_start_reg;
	reg [31:0] boot_setup_word0_reg;
	reg [31:0] boot_setup_word1_reg;
	reg [31:0] enc_len_reg; // Encrypted length
	reg [31:0] nonce_word_reg; // First nonce word, software view
	reg [6:0] err_reg; // Sticky error causes
	reg start_req_reg; // Software kick

	// Little-endian assembly: newest byte is most significant
	wire [31:0] word_le = {fl_data_i, shift_reg[31:8]};
	// Offset of first byte of the word that completes now
	wire [11:0] word_ofs = pos_reg - 12'h003;
	wire word_end = fl_valid_i && (pos_reg[1:0] == 2'b01);
	// Signed or encrypted images lock out the raw flash settings
	wire secured = sgn_s | enc_s;

	// ****************************************
	// CRC-16-CCITT byte step
	// ****************************************
	// Plain loop over eight bits; unrolled it is a few XOR levels
	// deep, which fits one cycle at this clock
	function [15:0] crc_step;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ {d, 8'h00};
			for (i = 0; i < 8; i = i + 1) begin
				r = r[15] ? ((r << 1) ^ `QBIP_CRC_POLY) : (r << 1);
			end
			crc_step = r;
		end
	endfunction

	// Header and section byte windows, check fields excluded
	wire in_hdr1 = (pos_reg >= `QBIP_OFS_HDR1) && (pos_reg < `QBIP_OFS_CRC1);
	wire in_hdr2 = (pos_reg >= `QBIP_OFS_HDR2) && (pos_reg < `QBIP_OFS_CRC2);

	// Destination range check
	// Cache SRAM destinations are not accepted here
	wire [31:0] dst = sram_destination_start_reg;
	wire [31:0] dst_end = dst + payload_length_reg - 32'h0000_0001;
	wire in_dbus = (dst >= `QBIP_DBUS_LO) && (dst_end <= `QBIP_DBUS_HI);
	wire in_sbus = (dst >= `QBIP_SBUS_LO) && (dst_end <= `QBIP_SBUS_HI);
	// Loader region may not take code; destination must clear its top
	wire hits_rsv = in_sbus && (dst <= `QBIP_RSV_HI);
	wire range_ok = in_dbus || (in_sbus && !hits_rsv);

	// Evaluation terms
	wire valid_bad = (image_validity_word_reg != VALID_WORD);
	wire crc1_bad = (check1_reg != {16'h0000, crc1_reg});
	wire crc2_bad = (check2_reg != {16'h0000, crc2_reg});
	wire enc_len_bad = enc_s && !usb_s && (enc_len_reg == 32'h0000_0000);

	// Parser sequencing
	always @(posedge clk_i) begin
		if (rst_i) begin
			// Words with an all-ones default reset to all ones, so a first parse after
			// reset that aborts before they arrive leaves the default settings on the outputs
			state_reg <= ST_IDLE;
			pos_reg <= 12'h000;
			shift_reg <= 32'h0000_0000;
			crc1_reg <= `QBIP_CRC_INIT;
			crc2_reg <= `QBIP_CRC_INIT;
			common_setup_word_reg <= 32'hFFFF_FFFF;
			image_validity_word_reg <= 32'h0000_0000;
			entry_reg <= 32'h0000_0000;
			pll_setup_word_reg <= 32'hFFFF_FFFF;
			flash_ctrl_word0_reg <= 32'hFFFF_FFFF;
			flash_ctrl_word1_reg <= 32'h0000_0000;
			flash_ctrl_word2_reg <= 32'h0000_0000;
			flash_address_offset_word_reg <= 32'h0000_0000;
			check1_reg <= 32'h0000_0000;
			check2_reg <= 32'h0000_0000;
			payload_length_reg <= 32'h0000_0000;
			sram_destination_start_reg <= 32'h0000_0000;
			boot_setup_word0_reg <= 32'hFFFF_FFFF;
			boot_setup_word1_reg <= 32'hFFFF_FFFF;
			enc_len_reg <= 32'h0000_0000;
			nonce_word_reg <= 32'h0000_0000;
			err_reg <= 7'h00;
			fl_req_o <= 1'b0;
			fl_addr_o <= 32'h0000_0000;
			done_o <= 1'b0;
			start_o <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// Wait for software kick, then stream from offset zero
				// Error flags clear only here, so they stay readable after a failure
				if (start_req_reg) begin
					state_reg <= ST_READ;
					pos_reg <= `QBIP_OFS_KEY;
					crc1_reg <= `QBIP_CRC_INIT;
					crc2_reg <= `QBIP_CRC_INIT;
					err_reg <= 7'h00;
					done_o <= 1'b0;
					start_o <= 1'b0;
					fl_req_o <= 1'b1;
					fl_addr_o <= 32'h0000_0000;
				end
			end
			ST_READ: begin
				if (fl_err_i) begin
					// Flash unreachable: stop, never start payload
					err_reg[0] <= 1'b1;
					fl_req_o <= 1'b0;
					state_reg <= ST_DONE;
				end else if (fl_valid_i) begin
					shift_reg <= word_le;
					pos_reg <= pos_reg + 12'h001;
					fl_addr_o <= fl_addr_o + 32'h0000_0001;
					// Key and signature bytes pass to the crypto engine
					// untouched; only counted here.
					if (in_hdr1) begin
						crc1_reg <= crc_step(crc1_reg, fl_data_i);
					end
					if (in_hdr2) begin
						crc2_reg <= crc_step(crc2_reg, fl_data_i);
					end
					// A word completes on its fourth byte; fields after the key start at 2 mod 4,
					// so the last byte of every field sits at 1 mod 4
					if (word_end) begin
						case (word_ofs)
						`QBIP_OFS_ENCLEN: enc_len_reg <= word_le;
						`QBIP_OFS_NONCE: nonce_word_reg <= word_le;
						`QBIP_OFS_COMMON: common_setup_word_reg <= word_le;
						`QBIP_OFS_VALID: image_validity_word_reg <= word_le;
						`QBIP_OFS_ENTRY: entry_reg <= word_le;
						`QBIP_OFS_PLL: pll_setup_word_reg <= word_le;
						`QBIP_OFS_FC0: flash_ctrl_word0_reg <= word_le;
						`QBIP_OFS_FC1: flash_ctrl_word1_reg <= word_le;
						`QBIP_OFS_FC2: flash_ctrl_word2_reg <= word_le;
						`QBIP_OFS_FC3: flash_address_offset_word_reg <= word_le;
						`QBIP_OFS_CRC1: check1_reg <= word_le;
						`QBIP_OFS_LEN: payload_length_reg <= word_le;
						`QBIP_OFS_DEST: sram_destination_start_reg <= word_le;
						`QBIP_OFS_BOOT0: boot_setup_word0_reg <= word_le;
						`QBIP_OFS_BOOT1: boot_setup_word1_reg <= word_le;
						`QBIP_OFS_CRC2: begin
							check2_reg <= word_le;
							fl_req_o <= 1'b0; // Header done; payload is copied elsewhere
							state_reg <= ST_EVAL;
						end
						default: begin
						end
						endcase
					end
				end
			end
			ST_EVAL: begin
				// Each failure cause gets its own flag
				err_reg[1] <= valid_bad;
				err_reg[2] <= crc1_bad;
				err_reg[3] <= crc2_bad;
				err_reg[4] <= enc_len_bad;
				err_reg[5] <= !range_ok;
				// Length zero is information only: an empty payload copies
				// nothing, so it does not hold back the start
				err_reg[6] <= (payload_length_reg == 32'h0000_0000);
				start_o <= !(valid_bad | crc1_bad | crc2_bad | enc_len_bad | !range_ok);
				done_o <= 1'b1;
				state_reg <= ST_DONE;
			end
			ST_DONE: begin
				done_o <= 1'b1;
				// A new kick returns to idle; a further kick reparses the image
				// Trade-off: a kick here only rearms; a second one is needed,
				// so a single stray write cannot restart a parse
				if (start_req_reg) begin
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// Decoded configuration outputs
	// ****************************************
	wire [1:0] clk_sel = common_setup_word_reg[`QBIP_CLK_HI:`QBIP_CLK_LO];
	wire pll_src = !clk_sel[1];
	wire ref_osc = (clk_sel == 2'b01) || (clk_sel == 2'b11);
	// Flash controller words 0 and 1 only honoured on plain flash boot; word 2 on any unsecured boot
	wire fc_ok = !secured && !usb_s;
	wire fc2_ok = !secured;
	wire ofs_en = fc_ok && flash_ctrl_word0_reg[`QBIP_OFSEN_BIT];

	// Registered decode of the latched words
	// Outputs follow the latched words every cycle; before the first
	// parse they show the defaults carried by the reset words
	always @(posedge clk_i) begin
		if (rst_i) begin
			entry_function_address_o <= 32'h0000_0000;
			flash_clock_divider_o <= `QBIP_DIV_OTHER;
			system_clock_select_o <= `QBIP_CLK_DEF;
			copy_dma_enable_o <= 1'b1;
			pll_reference_divider_o <= `QBIP_REF_OSC;
			pll_feedback_divider_o <= `QBIP_FB_DEF;
			pll_default_select_o <= 1'b1;
			flash_base_offset_o <= 32'h0000_0000;
			mic_address_o <= 32'h0000_0000;
			sram_init_end_o <= `QBIP_RSV_HI;
		end else begin
			entry_function_address_o <= entry_reg;
			system_clock_select_o <= clk_sel;
			if (common_setup_word_reg[`QBIP_DIVDEF_BIT]) begin
				flash_clock_divider_o <= pll_src ? `QBIP_DIV_PLL : `QBIP_DIV_OTHER;
			end else begin
				flash_clock_divider_o <= common_setup_word_reg[`QBIP_DIV_HI:`QBIP_DIV_LO];
			end
			// Secured or USB images always copy with DMA default
			copy_dma_enable_o <= fc_ok ? common_setup_word_reg[`QBIP_DMA_BIT] : 1'b1;
			pll_default_select_o <= pll_setup_word_reg[`QBIP_PLLDEF_BIT];
			if (pll_setup_word_reg[`QBIP_PLLDEF_BIT]) begin
				pll_reference_divider_o <= ref_osc ? `QBIP_REF_OSC : `QBIP_REF_XTAL;
				pll_feedback_divider_o <= `QBIP_FB_DEF;
			end else begin
				pll_reference_divider_o <= pll_setup_word_reg[`QBIP_REF_HI:`QBIP_REF_LO];
				pll_feedback_divider_o <= pll_setup_word_reg[`QBIP_FB_HI:`QBIP_FB_LO];
			end
			flash_base_offset_o <= ofs_en ? flash_address_offset_word_reg : 32'h0000_0000;
			// MIC sits right after the payload
			mic_address_o <= {20'h0_0000, `QBIP_OFS_PAYLOAD} + payload_length_reg;
			// Wake from deep sleep keeps the heap area untouched
			sram_init_end_o <= wake_s ? (`QBIP_HEAP_LO - 32'h0000_0001) : `QBIP_RSV_HI;
		end
	end

	// ****************************************
	// Wishbone slave, one registered ack a cycle after the request
	// ****************************************
	// Ack is registered and masks its own request, so each cycle gets
	// exactly one ack and the next request can follow with no idle cycle in between
	wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Ack and write side
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			start_req_reg <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			// Kick is a self-clearing pulse
			start_req_reg <= wb_hit && wb_we_i && wb_sel_i[0] &&
				(wb_adr_i == `QBIP_REG_CTRL) && wb_dat_i[0];
		end
	end

	// Read mux; unmapped reads return zero; USB hides non-header fields
	// Reads never disturb parser state; only CTRL has a side effect
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
			`QBIP_REG_STATUS: wb_dat_o <= {16'h0000, 1'b0, err_reg, 6'h00, start_o, done_o};
			`QBIP_REG_ENTRY: wb_dat_o <= entry_function_address_o;
			`QBIP_REG_LEN: wb_dat_o <= payload_length_reg;
			`QBIP_REG_DEST: wb_dat_o <= sram_destination_start_reg;
			`QBIP_REG_CLOCK: wb_dat_o <= common_setup_word_reg;
			`QBIP_REG_PLL: wb_dat_o <= pll_setup_word_reg;
			`QBIP_REG_FOFS: wb_dat_o <= flash_base_offset_o;
			`QBIP_REG_ENCLEN: wb_dat_o <= usb_s ? 32'h0000_0000 : enc_len_reg;
			`QBIP_REG_FC0: wb_dat_o <= fc_ok ? flash_ctrl_word0_reg : 32'h0000_0000;
			`QBIP_REG_FC1: wb_dat_o <= fc_ok ? flash_ctrl_word1_reg : 32'h0000_0000;
			`QBIP_REG_FC2: wb_dat_o <= fc2_ok ? flash_ctrl_word2_reg : 32'h0000_0000;
			`QBIP_REG_BOOT0: wb_dat_o <= boot_setup_word0_reg;
			`QBIP_REG_BOOT1: wb_dat_o <= boot_setup_word1_reg;
			`QBIP_REG_NONCE: wb_dat_o <= usb_s ? 32'h0000_0000 : nonce_word_reg;
			default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // qbip_parser

// ### bench/qbip_parser_asserts.sv
// Port-level checks for the boot image parser
`timescale 1ns/1ps
module qbip_parser_asserts (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Register bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Flash stream
	input wire fl_req_o,
	input wire [31:0] fl_addr_o,
	input wire fl_valid_i,
	// Straps and results
	input wire deep_sleep_wake_i,
	input wire done_o,
	input wire start_o,
	input wire [1:0] system_clock_select_o,
	input wire [8:0] pll_reference_divider_o,
	input wire [8:0] pll_feedback_divider_o,
	input wire pll_default_select_o,
	input wire [31:0] sram_init_end_o
);
	// ****
	// Clocking and sequences
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// A byte is consumed only while the parser asks for one
	sequence s_byte_taken;
		fl_req_o && fl_valid_i;
	endsequence
	// Last header byte before the payload
	sequence s_last_byte;
		s_byte_taken ##0 (fl_addr_o == 32'h0000_02B9);
	endsequence
	// ****
	// Properties
	// ****
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_addr_step;
		s_byte_taken |=> !fl_req_o || (fl_addr_o == $past(fl_addr_o) + 32'h0000_0001);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("flash address skipped");
	property p_addr_hold;
		fl_req_o && !fl_valid_i |=> !fl_req_o || $stable(fl_addr_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("flash address moved idle");
	property p_last_byte;
		s_last_byte |=> !fl_req_o ##[1:3] done_o;
	endproperty
	a_last_byte: assert property (p_last_byte) else $error("parse did not end at payload");
	property p_start_done;
		start_o |-> done_o;
	endproperty
	a_start_done: assert property (p_start_done) else $error("start without done");
	property p_idle_done;
		done_o |-> !fl_req_o;
	endproperty
	a_idle_done: assert property (p_idle_done) else $error("flash read after done");
	property p_ref_default;
		done_o && pll_default_select_o |->
			pll_reference_divider_o == (system_clock_select_o[0] ? 9'h050 : 9'h060);
	endproperty
	a_ref_default: assert property (p_ref_default) else $error("bad default ref divider");
	property p_fb_default;
		done_o && pll_default_select_o |-> pll_feedback_divider_o == 9'h0F0;
	endproperty
	a_fb_default: assert property (p_fb_default) else $error("bad default fb divider");
	property p_sram_warm;
		deep_sleep_wake_i [*5] |=> sram_init_end_o == 32'h2000_2657;
	endproperty
	a_sram_warm: assert property (p_sram_warm) else $error("heap not spared on wake");
endmodule // qbip_parser_asserts

// ### bench/qbip_flash_model.sv
// Serial flash model serving boot image bytes
`timescale 1ns/1ps
module qbip_flash_model (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Byte stream
	input wire req_i,
	input wire [31:0] addr_i,
	input wire slow_i,
	output reg valid_o,
	output wire [7:0] data_o
);
	// Image storage, filled by the bench
	logic [7:0] mem [0:1023];
	// Pacing: slow mode leaves one idle cycle after each byte
	always @(posedge clk_i) begin
		if (rst_i)
			valid_o <= 1'b0;
		else
			valid_o <= req_i && (!slow_i || !valid_o);
	end
	// Bytes leave in address order, low byte of a word first
	// Between bytes the lines show inverted data, so stale values never pass
	assign data_o = valid_o ? mem[addr_i[9:0]] : ~mem[addr_i[9:0]];
endmodule // qbip_flash_model

// ### bench/qbip_parser_bench.sv
// Self-checking bench for the boot image parser
`timescale 1ns/1ps
module qbip_parser_bench;
	localparam [31:0] IMG_VALID = 32'hA5C3_0F96; // Arbitrary value
	// ****
	// Signals
	// ****
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic signed_opt = 1'b0;
	logic usb = 1'b0;
	logic enc = 1'b0;
	logic fl_err = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wake = 1'b0;
	logic slow_mode = 1'b0;
	wire [31:0] wb_dat_o, fl_addr_o, entry_o, offset_o, mic_o, sram_end_o;
	wire wb_ack_o, fl_req_o, fl_valid, done_o, start_o, dma_o, pdef_o;
	wire [7:0] fl_data;
	wire [4:0] div_o;
	wire [1:0] sel_o;
	wire [8:0] ref_o, fb_o;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] rd, st;
	logic [7:0] ra;
	// Register reads 0x14 to 0x38 after a plain flash boot
	logic [31:0] r_exp [10] = '{32'hFFFF_FEFF, 32'hFFFF_FFFF, 32'h0000_0100, 32'h0000_0080,
		32'h0080_0000, 32'h0000_0C11, 32'h0000_6B03, 32'h7FFF_FFFF, 32'hFFEF_FFFF,
		32'h1357_9BDF};
	// Settings per pass and packed expected outputs
	logic [31:0] t_common [4] = '{32'hFFA9_FCFE, 32'hFFFF_FFFE, 32'hFFFF_FDFF, 32'hFFFF_FEFF};
	logic [31:0] t_pll [4] = '{32'hFE33_3BFE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
	logic [31:0] t_exp [4] = '{{5'h00, 5'h0A, 2'h0, 1'b0, 9'h033, 9'h077, 1'b0},
		{5'h00, 5'h01, 2'h3, 1'b1, 9'h050, 9'h0F0, 1'b1},
		{5'h00, 5'h04, 2'h1, 1'b1, 9'h050, 9'h0F0, 1'b1},
		{5'h00, 5'h01, 2'h2, 1'b1, 9'h060, 9'h0F0, 1'b1}};
	always #2 clk_i = ~clk_i;
	// ****
	// Design and flash
	// ****
	qbip_parser #(.VALID_WORD(IMG_VALID)) qbip_parser_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fl_req_o(fl_req_o), .fl_addr_o(fl_addr_o), .fl_valid_i(fl_valid), .fl_data_i(fl_data),
		.fl_err_i(fl_err), .usb_boot_i(usb), .signed_opt_i(signed_opt), .encrypted_opt_i(enc),
		.deep_sleep_wake_i(wake), .done_o(done_o), .start_o(start_o),
		.entry_function_address_o(entry_o), .flash_clock_divider_o(div_o),
		.system_clock_select_o(sel_o), .copy_dma_enable_o(dma_o),
		.pll_reference_divider_o(ref_o), .pll_feedback_divider_o(fb_o),
		.pll_default_select_o(pdef_o), .flash_base_offset_o(offset_o),
		.mic_address_o(mic_o), .sram_init_end_o(sram_end_o));
	qbip_flash_model qbip_flash_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(fl_req_o),
		.addr_i(fl_addr_o), .slow_i(slow_mode), .valid_o(fl_valid), .data_o(fl_data));
	// ****
	// Tasks
	// ****
	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic cycle; held until ack is sampled, bounded wait
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rdat);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_sel_i <= 4'h0;
		if (i == 16) begin
			err_count++;
			end_of_test();
		end
	endtask
	// Bench-side CRC, MSB first, so nothing is shared with the design
	function automatic logic [15:0] crc16(input int lo, input int hi);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int a = lo; a <= hi; a++) begin
			c = c ^ {qbip_flash_model_inst.mem[a], 8'h00};
			for (int b = 0; b < 8; b++)
				c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
	task automatic put(input int ofs, input logic [31:0] w);
		for (int k = 0; k < 4; k++)
			qbip_flash_model_inst.mem[ofs + k] = w[8*k +: 8];
	endtask
	task automatic build(input logic [31:0] common, input logic [31:0] pll,
		input logic [31:0] valid);
		for (int a = 0; a < 1024; a++)
			qbip_flash_model_inst.mem[a] = a[7:0] ^ 8'h5A;
		put(12'h242, common);
		put(12'h246, valid);
		put(12'h24A, 32'h0010_0400);
		put(12'h24E, pll);
		put(12'h256, 32'h0080_0000);
		put(12'h262, 32'h0000_0100);
		put(12'h226, 32'h0000_0080);
		put(12'h22A, 32'h1357_9BDF);
		put(12'h25A, 32'h0000_0C11);
		put(12'h25E, 32'h0000_6B03);
		put(12'h29E, 32'h7FFF_FFFF);
		put(12'h2A2, 32'hFFEF_FFFF);
		put(12'h28E, 32'h0000_0040);
		put(12'h296, 32'h2000_8000);
		put(12'h286, {16'h0000, crc16(12'h23A, 12'h285)});
		put(12'h2B6, {16'h0000, crc16(12'h28A, 12'h2B5)});
	endtask
	// Two kicks: the first only leaves a finished parse, the second starts; after reset the first starts
	task automatic run();
		int i;
		wb_cycle(1'b1, 8'h00, 32'h0000_0001, rd);
		wb_cycle(1'b1, 8'h00, 32'h0000_0001, rd);
		for (i = 0; i < 5000; i++) begin
			@(posedge clk_i);
			if (done_o === 1'b1)
				break;
		end
		if (i == 5000) begin
			err_count++;
			end_of_test();
		end
		wb_cycle(1'b0, 8'h04, 32'h0000_0000, st);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check(sram_end_o, 32'h2000_5657);
		check({5'h00, div_o, sel_o, dma_o, ref_o, fb_o, pdef_o}, t_exp[1]);
		for (int i = 0; i < 4; i++) begin
			signed_opt <= (i == 1);
			slow_mode <= i[0];
			build(t_common[i], t_pll[i], IMG_VALID);
			run();
			if (i != 1)
				check(st & 32'h0000_7F03, 32'h0000_0003);
			check({5'h00, div_o, sel_o, dma_o, ref_o, fb_o, pdef_o}, t_exp[i]);
			check(offset_o, (i == 1) ? 32'h0000_0000 : 32'h0000_0100);
			check(mic_o, 32'h0000_02FA);
			check(entry_o, 32'h0010_0400);
		end
		wb_cycle(1'b0, 8'h0C, 32'h0000_0000, rd);
		check(rd, 32'h0000_0040);
		wb_cycle(1'b0, 8'h10, 32'h0000_0000, rd);
		check(rd, 32'h2000_8000);
		wb_cycle(1'b1, 8'h08, 32'hFFFF_FFFF, rd);
		wb_cycle(1'b0, 8'h08, 32'h0000_0000, rd);
		check(rd, 32'h0010_0400);
		wb_cycle(1'b0, 8'hFC, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
		ra = 8'h14;
		for (int j = 0; j < 10; j++) begin
			wb_cycle(1'b0, ra, 32'h0000_0000, rd);
			check(rd, r_exp[j]);
			ra = ra + 8'h04;
		end
		// Broken validity word, first header, section header in turn
		for (int k = 0; k < 3; k++) begin
			build(32'hFFFF_FFFE, 32'hFFFF_FFFF, (k == 0) ? ~IMG_VALID : IMG_VALID);
			if (k != 0)
				qbip_flash_model_inst.mem[(k == 1) ? 12'h23A : 12'h28A] ^= 8'h01;
			run();
			check(st & 32'h0000_0E02, 32'h0000_0100 << (k + 1));
			check({31'h0, start_o}, 32'h0000_0000);
		end
		// USB boot of an encrypted image hides every non-header field
		usb <= 1'b1;
		enc <= 1'b1;
		build(32'hFFFF_FFFE, 32'hFFFF_FFFF, IMG_VALID);
		run();
		check(st & 32'h0000_7F03, 32'h0000_0003);
		check({31'h0, dma_o}, 32'h0000_0001);
		check(offset_o, 32'h0000_0000);
		ra = 8'h20;
		for (int j = 0; j < 4; j++) begin
			wb_cycle(1'b0, ra, 32'h0000_0000, rd);
			check(rd, 32'h0000_0000);
			ra = ra + 8'h04;
		end
		wb_cycle(1'b0, 8'h38, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
		wb_cycle(1'b0, 8'h30, 32'h0000_0000, rd);
		check(rd, 32'h7FFF_FFFF);
		// Encrypted flash boot with a zero length word must not start
		usb <= 1'b0;
		put(12'h226, 32'h0000_0000);
		run();
		check(st & 32'h0000_1003, 32'h0000_1001);
		wb_cycle(1'b0, 8'h2C, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
		wb_cycle(1'b0, 8'h38, 32'h0000_0000, rd);
		check(rd, 32'h1357_9BDF);
		// Flash failure while reading: own flag, no start
		enc <= 1'b0;
		fl_err <= 1'b1;
		run();
		fl_err <= 1'b0;
		check(st & 32'h0000_0103, 32'h0000_0101);
		wake <= 1'b1;
		repeat (8) @(posedge clk_i);
		check(sram_end_o, 32'h2000_2657);
		end_of_test();
	end
endmodule // qbip_parser_bench

bind qbip_parser qbip_parser_asserts qbip_parser_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_req_o(fl_req_o),
	.fl_addr_o(fl_addr_o), .fl_valid_i(fl_valid_i), .deep_sleep_wake_i(deep_sleep_wake_i),
	.done_o(done_o), .start_o(start_o), .system_clock_select_o(system_clock_select_o),
	.pll_reference_divider_o(pll_reference_divider_o),
	.pll_feedback_divider_o(pll_feedback_divider_o),
	.pll_default_select_o(pll_default_select_o), .sram_init_end_o(sram_init_end_o));
